/* common/nvw_pkg.sv */
// Purpose: shared constants and types of the nonvolatile write controller
// Assumes: AHB-Lite register access, 32-bit words, one per register
// Notes: all offsets are byte addresses
package nvw_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_ADDR = 8'h00;
  localparam logic [7:0] OFS_DATA = 8'h04;
  localparam logic [7:0] OFS_CTRL = 8'h08;
  localparam logic [7:0] OFS_UNLK = 8'h0C;
  localparam logic [7:0] OFS_STAT = 8'h10;
  localparam logic [7:0] OFS_MASK = 8'h14;
  localparam logic [7:0] OFS_SUSP = 8'h18;
  // control register bit positions
  localparam int B_MEMSEL = 7;
  localparam int B_CFGSEL = 6;
  localparam int B_WERR = 3;
  localparam int B_WEN = 2;
  localparam int B_WSTART = 1;
  // status register bit positions
  localparam int S_DONE = 0;
  localparam int S_ERR = 1;
  // unlock key values
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;
  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [1:0] STAT_RST = 2'h0;
  // timing: clock period, write time and power-up hold
  localparam int CLK_NS = 10;
  localparam int WRITE_US = 4;
  localparam int PWRT_US = 66;
  localparam int WRITE_CYC = (WRITE_US * 1000) / CLK_NS;
  localparam int PWRT_CYC = (PWRT_US * 1000) / CLK_NS;
  // states of the write sequencer
  typedef enum logic [1:0] {ST_IDLE, ST_ERASE, ST_PROG} nvw_state_t;
  // unlock tracker states
  typedef enum logic [1:0] {UK_IDLE, UK_GOT1, UK_ARMED} nvw_unlk_t;
  // request to the memory array
  typedef struct packed {
    logic we;
    logic erase;
    logic [7:0] addr;
    logic [7:0] data;
  } nvw_mreq_t;
endpackage

/* verilog/nvw_array.sv */
// Purpose: byte-wide nonvolatile array model with erase and program
// Assumes: one request per cycle, erase sets a byte to all ones
// Notes: external port refused while protection is active
`timescale 1ns/10ps
module nvw_array #(
  parameter int DEPTH = 256
) (
  input wire logic clock,
  input wire logic ce,
  input wire nvw_pkg::nvw_mreq_t req,
  input wire logic [7:0] rd_addr,
  output logic [7:0] rd_data,
  input wire logic protect,
  input wire logic ext_rd,
  input wire logic ext_we,
  input wire logic [7:0] ext_addr,
  input wire logic [7:0] ext_wdata,
  output logic [7:0] ext_rdata
);
  // storage; no reset, contents are nonvolatile
  logic [7:0] mem [DEPTH];
  logic [7:0] rd_next;
  logic [7:0] ext_next;

  ////////////////////////////////////////////////////////////////////////
  // read muxes
  always_comb begin
    rd_next = mem[rd_addr];
    ext_next = ext_rdata;
    if (ext_rd) begin
      // protected reads return zero
      ext_next = protect ? 8'h00 : mem[ext_addr]; // R08
    end
  end

  // writes; internal path ignores protection
  always_ff @(posedge clock) begin
    if (ce) begin
      rd_data <= rd_next;
      ext_rdata <= ext_next;
      if (req.we) begin
        mem[req.addr] <= req.erase ? 8'hFF : req.data; // R09 R18
      end else if (ext_we && !protect) begin
        mem[ext_addr] <= ext_wdata; // R08
      end
    end
  end
endmodule // nvw_array

/* verilog/nvw_ctrl.sv */
// Purpose: self-timed byte write controller for the data nonvolatile array
// Assumes: AHB-Lite slave, single word transfers, always OKAY
// Notes: processor reads of the array are a registered mux, no read strobe
// What the document requires
// R01 - 55h, AAh, then start; otherwise no write
// R02 - start ignored while write enable clear
// R03 - enable and start together do not start
// R04 - hardware never clears write enable
// R05 - control, address, data locked while writing
// R06 - finish clears start, sets done flag
// R07 - software clears done flag
// R08 - protection blocks external array access
// R09 - processor access ignores protection
// R10 - write enable resets to zero
// R11 - writes blocked during power-up timer
// R12 - software loads address and data first
// R13 - software disables interrupts around sequence
// R14 - software keeps write enable mostly clear
// R15 - select bits zero target data array
// R16 - start set only by software, cleared by hardware
// R17 - cut-short write sets write error
// R18 - erase then program, timed on-chip
// R19 - broken unlock order returns tracker to idle
//
// Decided for this implementation: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/10ps
module nvw_ctrl #(
  parameter int WRITE_CYC = nvw_pkg::WRITE_CYC,
  parameter int PWRT_CYC = nvw_pkg::PWRT_CYC,
  parameter int DEPTH = 256
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic irq,
  input wire logic protect,
  input wire logic ext_rd,
  input wire logic ext_we,
  input wire logic [7:0] ext_addr,
  input wire logic [7:0] ext_wdata,
  output logic [7:0] ext_rdata
);
  // registers
  logic [7:0] addr_reg, addr_next; // byte address
  logic [7:0] data_reg, data_next; // byte value
  logic [7:0] ctrl_reg, ctrl_next; // access control
  logic [1:0] stat_reg, stat_next; // sticky events
  logic [1:0] mask_reg, mask_next; // interrupt mask
  nvw_pkg::nvw_state_t st_reg, st_next;
  nvw_pkg::nvw_unlk_t uk_reg, uk_next;
  logic [31:0] cnt_reg, cnt_next; // cycle timer
  logic [31:0] pw_reg, pw_next; // power-up hold counter
  logic wrong_reg, wrong_next; // abort marker seen at reset
  // bus data phase capture
  logic dp_wr_reg, dp_wr_next;
  logic [7:0] dp_ofs_reg, dp_ofs_next;
  logic [31:0] rdata_next;
  logic [7:0] arr_rd;
  nvw_pkg::nvw_mreq_t mreq;
  logic addr_ph, wr_do;
  logic [7:0] wv;
  logic busy, pw_run;

  ////////////////////////////////////////////////////////////////////////
  // array instance
  nvw_array #(.DEPTH(DEPTH)) i_nvw_array (
    .clock(clock),
    .ce(ce),
    .req(mreq),
    .rd_addr(addr_reg),
    .rd_data(arr_rd),
    .protect(protect),
    .ext_rd(ext_rd),
    // external writes also wait out the power-up hold
    .ext_we(ext_we && !busy && !pw_run), // R11
    .ext_addr(ext_addr),
    .ext_wdata(ext_wdata),
    .ext_rdata(ext_rdata)
  );

  ////////////////////////////////////////////////////////////////////////
  // bus decode; slave never waits
  assign addr_ph = hsel && hready && htrans[1];
  assign wr_do = dp_wr_reg;
  assign wv = hwdata[7:0];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign busy = (st_reg != nvw_pkg::ST_IDLE);
  assign pw_run = (pw_reg != 32'h0000_0000);
  assign irq = |(stat_reg & mask_reg);

  // array request follows sequencer state
  always_comb begin
    mreq.we = 1'b0;
    mreq.erase = 1'b0;
    mreq.addr = addr_reg;
    mreq.data = data_reg;
    // erase at cycle start, program at its end
    if (st_reg == nvw_pkg::ST_ERASE && cnt_reg == 32'h0000_0000) begin
      mreq.we = 1'b1; // R18
      mreq.erase = 1'b1;
    end else if (st_reg == nvw_pkg::ST_PROG &&
                 cnt_reg == 32'h0000_0000) begin
      mreq.we = 1'b1; // R18
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // next-state logic for registers, unlock tracker and sequencer
  always_comb begin
    logic start_ok;
    logic bad_start;
    start_ok = 1'b0;
    bad_start = 1'b0;
    addr_next = addr_reg;
    data_next = data_reg;
    ctrl_next = ctrl_reg;
    stat_next = stat_reg;
    mask_next = mask_reg;
    st_next = st_reg;
    uk_next = uk_reg;
    cnt_next = cnt_reg;
    pw_next = pw_run ? pw_reg - 32'h0000_0001 : pw_reg; // R11
    wrong_next = wrong_reg;
    dp_wr_next = addr_ph && hwrite;
    dp_ofs_next = addr_ph ? haddr[7:0] : dp_ofs_reg;
    rdata_next = hrdata;
    // read data driven from flops in data phase
    if (addr_ph && !hwrite) begin
      case (haddr[7:0])
        nvw_pkg::OFS_ADDR: rdata_next = {24'h0, addr_reg};
        nvw_pkg::OFS_DATA: rdata_next = {24'h0, data_reg};
        nvw_pkg::OFS_CTRL: rdata_next = {24'h0, ctrl_reg};
        nvw_pkg::OFS_STAT: rdata_next = {30'h0, stat_reg};
        nvw_pkg::OFS_MASK: rdata_next = {30'h0, mask_reg};
        nvw_pkg::OFS_SUSP: rdata_next = {24'h0, arr_rd};
        default: rdata_next = 32'h0000_0000; // unlock port reads zero
      endcase
    end
    // here any access to another register but a control write breaks the key order
    if (addr_ph && haddr[7:0] != nvw_pkg::OFS_UNLK &&
        !(hwrite && haddr[7:0] == nvw_pkg::OFS_CTRL)) begin
      uk_next = nvw_pkg::UK_IDLE; // R19
    end
    if (wr_do) begin
      case (dp_ofs_reg)
        nvw_pkg::OFS_ADDR: if (!busy) addr_next = wv; // R05 R12
        nvw_pkg::OFS_DATA: if (!busy) data_next = wv; // R05 R12
        nvw_pkg::OFS_UNLK: begin
          // two-value key tracker
          if (uk_reg == nvw_pkg::UK_IDLE && wv == nvw_pkg::KEY_FIRST) begin
            uk_next = nvw_pkg::UK_GOT1; // R01
          end else if (uk_reg == nvw_pkg::UK_GOT1 &&
                       wv == nvw_pkg::KEY_SECOND) begin
            uk_next = nvw_pkg::UK_ARMED; // R01
          end else begin
            uk_next = nvw_pkg::UK_IDLE; // R19
          end
        end
        nvw_pkg::OFS_CTRL: if (!busy) begin // R05
          // select and enable bits are plain storage
          ctrl_next[nvw_pkg::B_MEMSEL] = wv[nvw_pkg::B_MEMSEL];
          ctrl_next[nvw_pkg::B_CFGSEL] = wv[nvw_pkg::B_CFGSEL];
          ctrl_next[nvw_pkg::B_WEN] = wv[nvw_pkg::B_WEN]; // R04
          ctrl_next[nvw_pkg::B_WERR] = wv[nvw_pkg::B_WERR];
          // enable must already be stored; selects count as written,
          // so a start that also picks another target stays refused
          if (wv[nvw_pkg::B_WSTART]) begin
            if (uk_reg == nvw_pkg::UK_ARMED && ctrl_reg[nvw_pkg::B_WEN] &&
                !pw_run && !wv[nvw_pkg::B_MEMSEL] &&
                !wv[nvw_pkg::B_CFGSEL]) begin
              start_ok = 1'b1; // R01 R02 R03 R11 R15
            end else if (uk_reg == nvw_pkg::UK_ARMED) begin
              bad_start = 1'b1; // R17
            end
          end
          uk_next = nvw_pkg::UK_IDLE; // R01
        end
        nvw_pkg::OFS_STAT: stat_next = stat_reg & ~wv[1:0]; // R07
        nvw_pkg::OFS_MASK: mask_next = wv[1:0];
        default: ; // unmapped writes ignored
      endcase
    end
    // sequencer: erase half, program half
    case (st_reg)
      nvw_pkg::ST_IDLE: begin
        if (start_ok) begin
          ctrl_next[nvw_pkg::B_WSTART] = 1'b1; // R16
          ctrl_next[nvw_pkg::B_WERR] = 1'b1; // cleared at proper finish
          wrong_next = 1'b1;
          st_next = nvw_pkg::ST_ERASE; // R18
          cnt_next = 32'h0000_0000;
        end
      end
      nvw_pkg::ST_ERASE: begin
        cnt_next = cnt_reg + 32'h0000_0001;
        if (cnt_reg == 32'(WRITE_CYC / 2)) begin
          st_next = nvw_pkg::ST_PROG;
          cnt_next = 32'(WRITE_CYC / 2);
        end
      end
      nvw_pkg::ST_PROG: begin
        cnt_next = cnt_reg - 32'h0000_0001;
        if (cnt_reg == 32'h0000_0000) begin
          st_next = nvw_pkg::ST_IDLE;
          ctrl_next[nvw_pkg::B_WSTART] = 1'b0; // R06 R16
          ctrl_next[nvw_pkg::B_WERR] = 1'b0;
          wrong_next = 1'b0;
          stat_next[nvw_pkg::S_DONE] = 1'b1; // R06
        end
      end
      default: st_next = nvw_pkg::ST_IDLE;
    endcase
    // improper attempt flags error; set wins over clear
    if (bad_start) begin
      ctrl_next[nvw_pkg::B_WERR] = 1'b1; // R17
      stat_next[nvw_pkg::S_ERR] = 1'b1; // R17
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state registers; reset mid-write leaves the error bit standing
  always_ff @(posedge clock) begin
    if (srst) begin
      addr_reg <= 8'h00;
      data_reg <= 8'h00;
      // werr survives reset when a write was cut short
      ctrl_reg <= {4'h0, wrong_reg, 3'h0}; // R10 R17
      stat_reg <= {wrong_reg, 1'b0}; // R17
      mask_reg <= nvw_pkg::STAT_RST;
      st_reg <= nvw_pkg::ST_IDLE;
      uk_reg <= nvw_pkg::UK_IDLE;
      cnt_reg <= 32'h0000_0000;
      pw_reg <= 32'(PWRT_CYC); // R11
      wrong_reg <= 1'b0;
      dp_wr_reg <= 1'b0;
      dp_ofs_reg <= 8'h00;
      hrdata <= 32'h0000_0000;
    end else if (ce) begin
      addr_reg <= addr_next;
      data_reg <= data_next;
      ctrl_reg <= ctrl_next;
      stat_reg <= stat_next;
      mask_reg <= mask_next;
      st_reg <= st_next;
      uk_reg <= uk_next;
      cnt_reg <= cnt_next;
      pw_reg <= pw_next;
      wrong_reg <= wrong_next;
      dp_wr_reg <= dp_wr_next;
      dp_ofs_reg <= dp_ofs_next;
      hrdata <= rdata_next;
    end
  end
endmodule // nvw_ctrl

/* verification/nvw_ctrl_asserts.sv */
// Purpose: port-level checks of the nonvolatile write controller
// Assumes: one clock, srst synchronous active high
// Notes: sees only the top ports, so checks are bus and port relations
`timescale 1ns/10ps
module nvw_ctrl_asserts (
  input wire logic clock,
  input wire logic srst,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic irq,
  input wire logic protect,
  input wire logic ext_rd,
  input wire logic [7:0] ext_rdata
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  // read address phase taken by the slave
  sequence rd_take;
    ce && hsel && hready && htrans[1] && !hwrite;
  endsequence
  sequence unl_take;
    rd_take ##0 haddr[7:0] == nvw_pkg::OFS_UNLK;
  endsequence
  sequence gap_take;
    rd_take ##0 haddr[7:0] == 8'h1C;
  endsequence
  sequence stat_take;
    rd_take ##0 haddr[7:0] == nvw_pkg::OFS_STAT;
  endsequence
  ready_const_a: assert property (hreadyout) else $error("wait state");
  resp_okay_a: assert property (!hresp) else $error("error response");
  ext_block_a: assert property (ce && ext_rd && protect |=>
    ext_rdata == 8'h00) else $error("protected read leaked");
  unlock_read_a: assert property (unl_take |=> hrdata == 32'h0)
    else $error("unlock port read nonzero");
  unmapped_zero_a: assert property (gap_take |=> hrdata == 32'h0)
    else $error("unmapped read nonzero");
  upper_zero_a: assert property (rd_take |=> hrdata[31:8] == 24'h0)
    else $error("upper read bits set");
  stat_bits_a: assert property (stat_take |=> hrdata[7:2] == 6'h0)
    else $error("unused status bits set");
  irq_reset_a: assert property ($fell(srst) |-> !irq)
    else $error("irq after reset");
  ce_freeze_a: assert property (!ce |=> $stable(hrdata) && $stable(irq))
    else $error("state moved with clock enable low");
endmodule // nvw_ctrl_asserts
////////////////////////////////////////
bind nvw_ctrl nvw_ctrl_asserts i_nvw_ctrl_asserts (.clock, .srst, .ce,
  .hsel, .haddr, .htrans, .hwrite, .hready, .hreadyout, .hresp, .hrdata,
  .irq, .protect, .ext_rd, .ext_rdata);

/* verification/nvw_ctrl_bench.sv */
// Purpose: self-checking bench of the nonvolatile write controller
// Assumes: zero-wait AHB-Lite slave, shortened write and hold counts
// Notes: array contents are seen through the read-back register
`timescale 1ns/10ps
module nvw_ctrl_bench;
  localparam int WC = 10; // short write time
  localparam int PC = 40; // hold long enough to start inside it
  logic clock = 1'b0, srst = 1'b1, ce = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic protect = 1'b0, ext_rd = 1'b0, ext_we = 1'b0, hreadyout, hresp, irq;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
  logic [7:0] ext_addr = 8'h21, ext_wdata = 8'h00, ext_rdata;
  int err_total = 0, n_checks = 0;
  // start attempts that must never write: preset, keys, start value
  logic [7:0] pre [7] = '{8'h00, 8'h00, 8'h04, 8'h04, 8'h04, 8'h04, 8'h04};
  logic [7:0] k1 [7] = '{8'h55, 8'h55, 8'h55, 8'h55, 8'hAA, 8'h55, 8'h55};
  logic [7:0] k2 [7] = '{8'hAA, 8'hAA, 8'hAA, 8'hAA, 8'h55, 8'h55, 8'hAA};
  logic [7:0] st [7] = '{8'h02, 8'h06, 8'h86, 8'h46, 8'h06, 8'h06, 8'h06};
  nvw_ctrl #(.WRITE_CYC(WC), .PWRT_CYC(PC)) i_nvw_ctrl (.clock, .srst,
    .ce, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .irq, .protect,
    .ext_rd, .ext_we, .ext_addr, .ext_wdata, .ext_rdata);
  initial forever #5 clock = ~clock;
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] s, e);
    n_checks++;
    if (s !== e) begin
      err_total++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // one single transfer; read data taken at the data phase end
  task automatic xf(input logic w, input logic [7:0] a, input [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge clock); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, d);
    xf(1'b1, a, {24'h0, d});
  endtask
  task automatic rc(input logic [7:0] a, e);
    xf(1'b0, a, 32'h0);
    chk(q, {24'h0, e});
  endtask
  // full proper sequence: address, value, enable, keys, start
  task automatic go(input logic [7:0] a, d);
    wr(8'h00, a);
    wr(8'h04, d);
    wr(8'h08, 8'h04);
    wr(8'h0C, 8'h55);
    wr(8'h0C, 8'hAA);
    wr(8'h08, 8'h06);
  endtask
  // bounded poll of the done flag
  task automatic wait_done;
    int n;
    n = 0;
    q = 32'h0;
    while (q[0] !== 1'b1 && n < 40) begin
      xf(1'b0, 8'h10, 32'h0);
      n++;
    end
    chk(q & 32'h1, 32'h1);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (5) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    rc(8'h08, 8'h00);
    rc(8'h10, 8'h00);
    rc(8'h0C, 8'h00);
    rc(8'h1C, 8'h00);
    go(8'h21, 8'h3C);
    rc(8'h08, 8'h0C);
    rc(8'h10, 8'h02);
    wr(8'h10, 8'h03);
    $display("test reset and hold done");
    repeat (PC) @(posedge clock);
    wr(8'h14, 8'h01);
    go(8'h21, 8'hA5);
    wr(8'h00, 8'h99);
    wr(8'h04, 8'h00);
    wr(8'h08, 8'h04);
    // error bit stands while writing, cleared at a proper finish
    rc(8'h08, 8'h0E);
    ce <= 1'b0;
    repeat (3) @(posedge clock);
    ce <= 1'b1;
    wait_done;
    chk(irq, 1'b1);
    rc(8'h08, 8'h04);
    wr(8'h08, 8'h00);
    rc(8'h00, 8'h21);
    rc(8'h04, 8'hA5);
    rc(8'h18, 8'hA5);
    rc(8'h10, 8'h01);
    wr(8'h14, 8'h00);
    @(posedge clock);
    chk(irq, 1'b0);
    wr(8'h14, 8'h01);
    @(posedge clock);
    chk(irq, 1'b1);
    wr(8'h10, 8'h01);
    @(posedge clock);
    chk(irq, 1'b0);
    $display("test write done");
    for (int i = 0; i < 7; i++) begin
      wr(8'h04, 8'h5A);
      wr(8'h08, pre[i]);
      wr(8'h0C, k1[i]);
      // other register touched between keys
      if (i == 6) wr(8'h00, 8'h21);
      wr(8'h0C, k2[i]);
      wr(8'h08, st[i]);
      xf(1'b0, 8'h08, 32'h0);
      chk(q & 32'h2, 32'h0);
      repeat (WC + 4) @(posedge clock);
      rc(8'h18, 8'hA5);
    end
    $display("test refused starts done");
    protect <= 1'b1;
    ext_we <= 1'b1;
    @(posedge clock);
    ext_we <= 1'b0;
    ext_rd <= 1'b1;
    @(posedge clock);
    ext_rd <= 1'b0;
    @(negedge clock);
    chk(ext_rdata, 8'h00);
    @(posedge clock);
    rc(8'h18, 8'hA5);
    go(8'h21, 8'h5A);
    wait_done;
    rc(8'h18, 8'h5A);
    protect <= 1'b0;
    ext_rd <= 1'b1;
    @(posedge clock);
    ext_rd <= 1'b0;
    @(negedge clock);
    chk(ext_rdata, 8'h5A);
    // unprotected external write lands; one more edge for the read flop
    @(posedge clock);
    ext_wdata <= 8'h3C;
    ext_we <= 1'b1;
    @(posedge clock);
    ext_we <= 1'b0;
    @(posedge clock);
    rc(8'h18, 8'h3C);
    $display("test protection done");
    @(posedge clock);
    go(8'h22, 8'h11);
    repeat (3) @(posedge clock);
    srst <= 1'b1;
    @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    rc(8'h08, 8'h08);
    rc(8'h10, 8'h02);
    $display("test cut short done");
    print_verdict;
  end
  // hang guard, far beyond the few hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge clock);
    err_total++;
    print_verdict;
  end
endmodule // nvw_ctrl_bench
